/* File: hw/acrw_regs.svh */
// Purpose: offsets, field positions and counts for the channel map block
// Assumes: included by the package and by the core
// Notes: command byte layout is read flag plus register select
`ifndef ACRW_REGS_SVH
`define ACRW_REGS_SVH
`define ACRW_CMD_READ_BIT 7
`define ACRW_CMD_SEL_HI 3
`define ACRW_RESULT_SEL 4'h3
`define ACRW_CMD_BITS 5'd8
`define ACRW_READ_BITS 5'd24
`define ACRW_SINK_BITS 5'd8
`define ACRW_WORD_W 24
`define ACRW_VAL_W 18
`define ACRW_CONV_W 20
`define ACRW_VAL_LSB 6
`define ACRW_ZERO_HI 5
`define ACRW_ZERO_LO 3
`define ACRW_TAG_HI 2
`define ACRW_CONV_MAX 20'sh1ffff
`define ACRW_CONV_MIN -20'sh20000
`define ACRW_OB_FLIP 18'h20000
`define ACRW_VAL_MAX 18'h3ffff
`define ACRW_VAL_MIN 18'h00000
`define ACRW_TAG_CAL 3'h7
`define ACRW_SCAN_PSEUDO 3'd5
`define ACRW_SCAN_PAIR_WIRING_SELECT 3'd3
`define ACRW_SCAN_CAL_EXTRA 3'd2
`define ACRW_CODE_W 4
`define ACRW_FIFO_DEPTH 2
`endif

/* File: hw/acrw_pkg.sv */
// Purpose: types shared by the channel map block
// Assumes: acrw_regs.svh holds the word width; mode, channel and link state codes are set here
// Notes: link states are gray along idle, read, idle and idle, sink, idle
`include "acrw_regs.svh"
package acrw_pkg;
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_OFFSET_CAL = 2'h1,
		MODE_GAIN_CAL = 2'h2,
		MODE_RESERVED = 2'h3
	} acrw_mode_e;
	typedef enum logic [3:0] {
		CH_P1 = 4'h0,
		CH_P2 = 4'h1,
		CH_P3 = 4'h2,
		CH_P4 = 4'h3,
		CH_D12 = 4'h4,
		CH_D34 = 4'h5,
		CH_D56 = 4'h6,
		CH_OFFSET_CAL = 4'h7,
		CH_GAIN_CAL = 4'h8
	} acrw_chan_e;
	typedef enum logic [1:0] {
		L_CMD = 2'h0,
		L_READ = 2'h1,
		L_SINK = 2'h2
	} acrw_link_e;
	typedef logic [`ACRW_WORD_W-1:0] acrw_word_t;
endpackage

/* File: hw/acrw_core.sv */
// Purpose: channel to setting-group map, offset decode, result word and serial read
// Assumes: config and conversion inputs are on i_clock; link pins come from the host
// Notes: link logic runs on the host serial clock and is cleared while select is high
// Operation
// - normal unscanned: inputs 1,2 group 1; 3,4 group 2; pair 5-6 group 3
// - offset cal unscanned: offset pair, group as select bits pick in normal mode
// - gain cal unscanned: gain pair, group chosen exactly like offset calibration
// - cal scan: all signal channels then both cal pairs, cal pairs use group 3
// - offset code: sign plus 3-bit magnitude; zero magnitude disconnects source
// - result is a read-only 24-bit register; writes leave it unchanged
// - write to result: host clocks 8 more bits, then link awaits new command
// - word goes msb first: 18 result bits, three zeros, 3-bit source tag
// - result is offset binary, all zeros minimum, all ones maximum
// - out-of-range inputs saturate to minimum or maximum, never wrap
// - tags 0-3 pseudo inputs 1-4, 4-6 pair_wiring_select pairs and input 5, 7 calibration
// - mode 00 normal, 01 offset cal, 10 gain cal, 11 reserved
// - cal scan converts offset pair before gain pair, same tag
`timescale 1ns/1ps
`include "acrw_regs.svh"
module acrw_core
	import acrw_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// configuration
	input wire logic [1:0] i_op_mode,
	input wire logic i_pair_wiring_select,
	input wire logic i_scan,
	input wire logic [1:0] i_channel_select,
	input wire logic [3*`ACRW_CODE_W-1:0] i_offset_codes,
	input wire logic [2:0] i_unipolar,
	// conversion stream
	input wire logic i_conv_valid,
	input wire logic signed [`ACRW_CONV_W-1:0] i_conv_data,
	output logic o_conv_ready,
	// channel map outputs
	output logic [3:0] o_active_chan,
	output logic [1:0] o_active_group,
	output logic [2:0] o_source_tag,
	output logic o_mode_fault,
	output logic o_select_fault,
	// offset source control
	output logic o_offset_connect,
	output logic o_offset_negative,
	output logic [3:0] o_offset_twelfths,
	// serial link
	input wire logic i_link_sclk,
	input wire logic i_link_sel_n,
	input wire logic i_link_din,
	output logic o_link_dout,
	output logic o_link_dout_oe
);

	function automatic logic [1:0] group_of(input acrw_chan_e ch, input logic scanning);
		case (ch)
			CH_P1, CH_P2, CH_D12: group_of = 2'h1;
			CH_P3, CH_P4, CH_D34: group_of = 2'h2;
			CH_D56: group_of = 2'h3;
			default: group_of = scanning ? 2'h3 : 2'h0;
		endcase
	endfunction

	function automatic logic [2:0] tag_of(input acrw_chan_e ch);
		case (ch)
			CH_OFFSET_CAL, CH_GAIN_CAL: tag_of = `ACRW_TAG_CAL;
			default: tag_of = ch[2:0];
		endcase
	endfunction

	// channel the select bits pick in normal mode
	function automatic acrw_chan_e normal_pick(input logic pw, input logic [1:0] sel);
		if (pw) begin
			normal_pick = acrw_chan_e'({2'h1, sel});
		end else begin
			normal_pick = acrw_chan_e'({2'h0, sel});
		end
	endfunction

	acrw_mode_e mode;
	logic cal_mode;
	logic [2:0] scan_len;
	logic [2:0] seq_q;
	logic [2:0] seq_d;
	acrw_chan_e scan_chan;
	acrw_chan_e fixed_chan;
	acrw_chan_e chan;
	logic [1:0] group;
	logic conv_take;
	logic sel_meta_q;
	logic sel_sync_q;
	logic frame_busy;

	assign mode = acrw_mode_e'(i_op_mode);
	assign o_mode_fault = (mode == MODE_RESERVED);
	assign o_select_fault = i_pair_wiring_select & (&i_channel_select) & ~i_scan;
	assign cal_mode = (mode == MODE_OFFSET_CAL) | (mode == MODE_GAIN_CAL);
	assign scan_len = (i_pair_wiring_select ? `ACRW_SCAN_PAIR_WIRING_SELECT : `ACRW_SCAN_PSEUDO)
		+ (cal_mode ? `ACRW_SCAN_CAL_EXTRA : 3'd0);

	// scan list: signal channels first, then offset pair, then gain pair
	always_comb begin
		scan_chan = CH_OFFSET_CAL;
		if (seq_q >= scan_len - 3'd1 && cal_mode) begin
			scan_chan = CH_GAIN_CAL;
		end else if (seq_q >= scan_len - 3'd2 && cal_mode) begin
			scan_chan = CH_OFFSET_CAL;
		end else if (i_pair_wiring_select) begin
			scan_chan = acrw_chan_e'({2'h1, seq_q[1:0]});
		end else if (seq_q == 3'd4) begin
			scan_chan = CH_D56;
		end else begin
			scan_chan = acrw_chan_e'({2'h0, seq_q[1:0]});
		end
	end

	assign fixed_chan = (mode == MODE_OFFSET_CAL) ? CH_OFFSET_CAL :
		(mode == MODE_GAIN_CAL) ? CH_GAIN_CAL :
		normal_pick(i_pair_wiring_select, i_channel_select);
	assign chan = i_scan ? scan_chan : fixed_chan;
	// unscanned cal pairs borrow the group that the select bits pick
	assign group = (!i_scan && cal_mode) ?
		group_of(normal_pick(i_pair_wiring_select, i_channel_select), 1'b0) :
		group_of(chan, i_scan);
	assign o_active_chan = chan;
	assign o_active_group = group;
	assign o_source_tag = tag_of(chan);

	// offset code of the active group
	logic [1:0] grp_idx;
	logic [`ACRW_CODE_W-1:0] code;
	logic [2:0] mag;
	assign grp_idx = (group == 2'h0) ? 2'h0 : group - 2'h1;
	assign code = i_offset_codes[grp_idx*`ACRW_CODE_W +: `ACRW_CODE_W];
	assign mag = code[2:0];
	assign o_offset_connect = (mag != 3'h0);
	assign o_offset_negative = code[3] & o_offset_connect;
	// unipolar steps are twice the bipolar ones
	assign o_offset_twelfths = i_unipolar[grp_idx] ? {mag, 1'b0} : {1'b0, mag};

	// saturating offset-binary format
	logic [`ACRW_VAL_W-1:0] sat_val;
	acrw_word_t conv_word;
	assign sat_val = (i_conv_data > `ACRW_CONV_MAX) ? `ACRW_VAL_MAX :
		(i_conv_data < `ACRW_CONV_MIN) ? `ACRW_VAL_MIN :
		(i_conv_data[`ACRW_VAL_W-1:0] ^ `ACRW_OB_FLIP);
	assign conv_word = {sat_val, 3'h0, tag_of(chan)};

	// two-entry buffer; drains only outside host frames
	acrw_word_t fifo_mem [`ACRW_FIFO_DEPTH];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic fifo_full;
	logic fifo_empty;
	logic pop;
	acrw_word_t result_q;
	assign fifo_full = (count_q == 2'd2);
	assign fifo_empty = (count_q == 2'd0);
	assign o_conv_ready = ~fifo_full & ~o_mode_fault;
	assign conv_take = i_conv_valid & o_conv_ready;
	assign frame_busy = ~sel_sync_q;
	assign pop = ~fifo_empty & ~frame_busy;
	assign seq_d = (seq_q >= scan_len - 3'd1) ? 3'd0 : seq_q + 3'd1;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sel_meta_q <= 1'b1;
			sel_sync_q <= 1'b1;
		end else if (i_clk_en) begin
			sel_meta_q <= i_link_sel_n;
			sel_sync_q <= sel_meta_q;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			seq_q <= 3'd0;
		end else if (i_clk_en) begin
			if (!i_scan || seq_q >= scan_len) begin
				seq_q <= 3'd0;
			end else if (conv_take) begin
				seq_q <= seq_d;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'd0;
			result_q <= '0;
		end else if (i_clk_en) begin
			if (conv_take) begin
				fifo_mem[wr_ptr_q] <= conv_word;
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				result_q <= fifo_mem[rd_ptr_q];
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= count_q + {1'b0, conv_take} - {1'b0, pop};
		end
	end

	// link side; result_q is frozen while a frame is open so it is quasi-static here
	acrw_link_e lstate_q;
	logic [4:0] lcnt_q;
	acrw_word_t shift_q;
	logic [7:0] cmd;
	logic cmd_result;
	assign cmd = {shift_q[6:0], i_link_din};
	assign cmd_result = (cmd[`ACRW_CMD_SEL_HI:0] == `ACRW_RESULT_SEL);
	assign o_link_dout = shift_q[`ACRW_WORD_W-1];
	assign o_link_dout_oe = (lstate_q == L_READ) & ~i_link_sel_n;

	always_ff @(posedge i_link_sclk or posedge i_link_sel_n) begin
		if (i_link_sel_n) begin
			lstate_q <= L_CMD;
			lcnt_q <= 5'd0;
			shift_q <= '0;
		end else begin
			case (lstate_q)
				L_CMD: begin
					shift_q <= {shift_q[`ACRW_WORD_W-2:0], i_link_din};
					lcnt_q <= lcnt_q + 5'd1;
					if (lcnt_q == `ACRW_CMD_BITS - 5'd1) begin
						lcnt_q <= 5'd0;
						if (cmd_result && cmd[`ACRW_CMD_READ_BIT]) begin
							shift_q <= result_q;
							lstate_q <= L_READ;
						end else if (cmd_result) begin
							lstate_q <= L_SINK;
						end
					end
				end
				L_READ: begin
					shift_q <= {shift_q[`ACRW_WORD_W-2:0], 1'b0};
					lcnt_q <= lcnt_q + 5'd1;
					if (lcnt_q == `ACRW_READ_BITS - 5'd1) begin
						lcnt_q <= 5'd0;
						lstate_q <= L_CMD;
					end
				end
				L_SINK: begin
					lcnt_q <= lcnt_q + 5'd1;
					if (lcnt_q == `ACRW_SINK_BITS - 5'd1) begin
						lcnt_q <= 5'd0;
						lstate_q <= L_CMD;
					end
				end
				default: begin
					lstate_q <= L_CMD;
					lcnt_q <= 5'd0;
				end
			endcase
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	a_normal_group_map: assert property (
		mode == MODE_NORMAL && !i_scan && !i_pair_wiring_select |->
			o_active_group == (i_channel_select[1] ? 2'h2 : 2'h1))
		else $error("normal pseudo group wrong");
	a_offcal_group_follow: assert property (
		mode == MODE_OFFSET_CAL && !i_scan && !o_select_fault |->
			o_active_chan == CH_OFFSET_CAL &&
			o_active_group == (i_pair_wiring_select ? i_channel_select + 2'h1 :
				(i_channel_select[1] ? 2'h2 : 2'h1)))
		else $error("offset cal group wrong");
	a_gaincal_group_follow: assert property (
		mode == MODE_GAIN_CAL && !i_scan && i_pair_wiring_select && i_channel_select == 2'h2 |->
			o_active_chan == CH_GAIN_CAL && o_active_group == 2'h3)
		else $error("gain cal group wrong");
	a_scan_cal_group: assert property (
		i_scan && (o_active_chan == CH_OFFSET_CAL || o_active_chan == CH_GAIN_CAL) |->
			o_active_group == 2'h3 && cal_mode)
		else $error("scan cal pair not group 3");
	sequence s_offcal_taken;
		i_scan && o_active_chan == CH_OFFSET_CAL && conv_take;
	endsequence
	a_scan_cal_order: assert property (
		s_offcal_taken ##1 (i_scan && $stable(i_op_mode) && $stable(i_pair_wiring_select)) |->
			o_active_chan == CH_GAIN_CAL)
		else $error("gain pair did not follow offset pair");
	a_offset_disconnect: assert property (
		mag == 3'h0 |-> !o_offset_connect && !o_offset_negative && o_offset_twelfths == 4'h0)
		else $error("zero offset magnitude still connected");
	a_result_frozen: assert property (
		frame_busy && i_clk_en |=> $stable(result_q))
		else $error("result changed during a frame");
	a_result_zero_bits: assert property (
		result_q[`ACRW_ZERO_HI:`ACRW_ZERO_LO] == 3'h0)
		else $error("reserved result bits not zero");
	a_sat_limits: assert property (
		(i_conv_data > `ACRW_CONV_MAX |-> sat_val == `ACRW_VAL_MAX) and
		(i_conv_data < `ACRW_CONV_MIN |-> sat_val == `ACRW_VAL_MIN))
		else $error("result wrapped instead of saturating");
	a_offset_binary_mid: assert property (
		i_conv_data == '0 |-> sat_val == `ACRW_OB_FLIP)
		else $error("zero input not mid code");
	a_word_paired: assert property (
		conv_take && i_clk_en && fifo_empty && !frame_busy |=>
			##1 result_q == $past(conv_word, 2))
		else $error("result and tag not stored together");
	a_cal_tag: assert property (
		o_active_chan == CH_OFFSET_CAL || o_active_chan == CH_GAIN_CAL |->
			o_source_tag == `ACRW_TAG_CAL)
		else $error("calibration tag wrong");
	a_mode_reserved: assert property (
		i_op_mode == 2'h3 |-> o_mode_fault && !o_conv_ready)
		else $error("reserved mode accepted");
	a_sink_eight: assert property (
		@(posedge i_link_sclk) disable iff (i_link_sel_n)
		$rose(lstate_q == L_SINK) |-> (lstate_q == L_SINK) [*8] ##1 lstate_q == L_CMD)
		else $error("write sink not eight bits");

endmodule

/* File: sim/acrw_host_model.sv */
// Purpose: host end of the serial link, opens frames and gathers read bits
// Assumes: link clock idles low and stands still between frames
// Notes: din shows the inverse of its last bit while no frame is open
`timescale 1ns/1ps
module acrw_host_model (
	// link outputs
	output logic o_sclk,
	output logic o_sel_n,
	output logic o_din,
	// device data
	input wire logic i_dout
);
	initial begin
		o_sclk = 1'b0;
		o_sel_n = 1'b1;
		o_din = 1'b0;
	end
	// bits are msb aligned; rd keeps the last 24 dout samples
	task automatic frame(input logic [63:0] bits, input int n, output logic [23:0] rd);
		int i;
		rd = 24'h0;
		o_sel_n = 1'b0;
		#10;
		for (i = 0; i < n; i++) begin
			rd = {rd[22:0], i_dout};
			o_din = bits[63-i];
			#7.5 o_sclk = 1'b1;
			#7.5 o_sclk = 1'b0;
		end
		#10 o_sel_n = 1'b1;
		o_din = ~o_din;
		// select stays high long enough for a result update
		#100;
	endtask
endmodule

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for channel map, offset decode and result word
// Assumes: host model owns the link pins, bench owns config and conversions
// Notes: expectations come from the map tables and the word layout
`timescale 1ns/1ps
module tb_top;
	import acrw_pkg::*;
	logic i_clock, i_rst, i_clk_en, i_pair_wiring_select, i_scan, i_conv_valid;
	logic [1:0] i_op_mode, i_channel_select, o_active_group;
	logic [11:0] i_offset_codes;
	logic [2:0] i_unipolar, o_source_tag;
	logic signed [19:0] i_conv_data;
	logic o_conv_ready, o_mode_fault, o_select_fault, o_offset_connect, o_offset_negative;
	logic [3:0] o_active_chan, o_offset_twelfths;
	logic sclk, sel_n, din, dout, dout_oe;
	logic [23:0] w;
	logic signed [19:0] vals [6];
	logic [17:0] exps [6];
	int n_errors = 0;
	int checked = 0;
	int m, d, s, k, n, p;
	acrw_core acrw_core_i (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
		.i_op_mode(i_op_mode), .i_pair_wiring_select(i_pair_wiring_select), .i_scan(i_scan),
		.i_channel_select(i_channel_select), .i_offset_codes(i_offset_codes),
		.i_unipolar(i_unipolar), .i_conv_valid(i_conv_valid), .i_conv_data(i_conv_data),
		.o_conv_ready(o_conv_ready), .o_active_chan(o_active_chan),
		.o_active_group(o_active_group), .o_source_tag(o_source_tag),
		.o_mode_fault(o_mode_fault), .o_select_fault(o_select_fault),
		.o_offset_connect(o_offset_connect), .o_offset_negative(o_offset_negative),
		.o_offset_twelfths(o_offset_twelfths), .i_link_sclk(sclk), .i_link_sel_n(sel_n),
		.i_link_din(din), .o_link_dout(dout), .o_link_dout_oe(dout_oe));
	acrw_host_model acrw_host_model_i (.o_sclk(sclk), .o_sel_n(sel_n), .o_din(din),
		.i_dout(dout));
	task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cfg(input int mo, input int df, input int sc, input int se);
		@(posedge i_clock);
		i_op_mode <= 2'(mo);
		i_pair_wiring_select <= 1'(df);
		i_scan <= 1'(sc);
		i_channel_select <= 2'(se);
		@(negedge i_clock);
	endtask
	// ready is looked at mid-cycle so the take edge is known
	task automatic conv(input logic signed [19:0] v);
		@(posedge i_clock);
		i_conv_valid <= 1'b1;
		i_conv_data <= v;
		do @(negedge i_clock); while (o_conv_ready !== 1'b1);
		@(posedge i_clock);
		i_conv_valid <= 1'b0;
	endtask
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
	initial begin
		i_rst = 1'b1;
		i_clk_en = 1'b1;
		i_op_mode = 2'h0;
		i_pair_wiring_select = 1'b0;
		i_scan = 1'b0;
		i_channel_select = 2'h0;
		i_offset_codes = 12'h0;
		i_unipolar = 3'h0;
		i_conv_valid = 1'b0;
		i_conv_data = 20'h0;
		vals = '{20'h0, 20'he0000, 20'h1ffff, 20'h30d40, 20'hb6c20, 20'h5};
		exps = '{18'h20000, 18'h0, 18'h3ffff, 18'h3ffff, 18'h0, 18'h20005};
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		@(negedge i_clock);
		acrw_host_model_i.frame({8'h83, 56'h0}, 32, w);
		chk("reset word", w, 24'h0);
		for (m = 0; m < 4; m++) begin
			for (d = 0; d < 2; d++) begin
				for (s = 0; s < 4; s++) begin
					cfg(m, d, 0, s);
					chk("mode fault", o_mode_fault, m == 3);
					chk("ready", o_conv_ready, m != 3);
					chk("select fault", o_select_fault, d == 1 && s == 3);
					if (m < 3 && !(d == 1 && s == 3)) begin
						k = (m == 0) ? (d ? 4 + s : s) : 7;
						chk("group", o_active_group, d ? s + 1 : (s > 1) + 1);
						chk("tag", o_source_tag, k);
						chk("chan", o_active_chan, k + (m == 2));
					end
				end
			end
		end
		for (m = 0; m < 3; m++) begin
			for (d = 0; d < 2; d++) begin
				cfg(m, d, 0, 0);
				cfg(m, d, 1, 3);
				n = (d ? 3 : 5) + (m ? 2 : 0);
				for (s = 0; s <= n; s++) begin
					p = s % n;
					k = d ? p + 4 : (p < 4 ? p : p + 2);
					chk("scan chan", o_active_chan, k);
					chk("scan group", o_active_group, k > 5 ? 3 : (k > 3 ? k - 3 : k / 2 + 1));
					chk("scan tag", o_source_tag, k > 7 ? 7 : k);
					conv(20'h0);
					@(negedge i_clock);
				end
			end
		end
		for (s = 0; s < 6; s++) begin
			cfg(0, 0, 0, s % 4);
			conv(vals[s]);
			repeat (5) @(posedge i_clock);
			acrw_host_model_i.frame({8'h83, 56'h0}, 32, w);
			chk("word", w, {exps[s], 3'h0, 3'(s % 4)});
			chk("oe idle", dout_oe, 0);
		end
		// a word offered with the enable low must not reach the result
		@(posedge i_clock);
		i_clk_en <= 1'b0;
		conv(20'h7);
		@(posedge i_clock);
		i_clk_en <= 1'b1;
		repeat (5) @(posedge i_clock);
		acrw_host_model_i.frame({8'h83, 56'h0}, 32, w);
		chk("frozen word", w, {18'h20005, 6'h1});
		acrw_host_model_i.frame({8'h03, 8'h5a, 8'h83, 40'h0}, 48, w);
		chk("after write", w, {18'h20005, 6'h1});
		acrw_host_model_i.frame({8'h05, 8'h83, 48'h0}, 40, w);
		chk("after other", w, {18'h20005, 6'h1});
		for (s = 0; s < 32; s++) begin
			k = s % 8;
			@(posedge i_clock);
			i_offset_codes <= {8'h0, 4'(s)};
			i_unipolar <= 3'(s / 16);
			@(negedge i_clock);
			chk("connect", o_offset_connect, k != 0);
			chk("negative", o_offset_negative, (s % 16) > 8);
			chk("twelfths", o_offset_twelfths, s > 15 ? 2 * k : k);
		end
		// codes differ per group so a wrong group index shows
		@(posedge i_clock);
		i_offset_codes <= 12'hb50;
		i_unipolar <= 3'h4;
		cfg(0, 1, 0, 2);
		chk("grp3 connect", o_offset_connect, 1);
		chk("grp3 negative", o_offset_negative, 1);
		chk("grp3 twelfths", o_offset_twelfths, 6);
		cfg(0, 1, 0, 1);
		chk("grp2 negative", o_offset_negative, 0);
		chk("grp2 twelfths", o_offset_twelfths, 5);
		end_of_test();
	end
endmodule
